// [rtl/hip_sequencer.sv]
// Power sequencer for a hot-inserted board: connect, ramp, cycle, breaker
`timescale 1ns/1ps
module hip_sequencer
  import hip_pkg::*;
#(
  parameter int unsigned QUALIFY_COUNT = QUALIFY_CYC,
  parameter int unsigned SETTLE_COUNT = SETTLE_CYC
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Backplane pins
  input wire logic connect_sense_a_n,
  input wire logic connect_sense_b_n,
  input wire logic pwr_cycle_req_n,
  // Analog status
  input wire logic low_rail_input_ok,
  input wire logic high_rail_input_ok,
  input wire logic low_rail_output_ok,
  input wire logic outputs_below_trip,
  input wire logic overcurrent_sense,
  // Supply control
  output logic ramp_current_en,
  output logic low_rail_gate_drive,
  output logic high_rail_gate_drive,
  output logic gate_discharge,
  output logic neg_supply_enable,
  // Board supervision
  output logic supply_good_out,
  output logic sys_reset_n,
  output logic bus_isolate,
  output logic fault_n
);

  // ==========================================================================
  // Pin synchronisers
  logic [SYNC_W-1:0] pins;
  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;

  assign pins = {overcurrent_sense, outputs_below_trip, low_rail_output_ok,
                 high_rail_input_ok, low_rail_input_ok, pwr_cycle_req_n,
                 connect_sense_b_n, connect_sense_a_n};

  // Two stages before any logic
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      sync1_q <= RST_SYNC;
      sync2_q <= RST_SYNC;
    end else begin
      sync1_q <= pins;
      sync2_q <= sync1_q;
    end
  end

  logic conn_a_n_s, conn_b_n_s, req_n_s, uvlo_ok_s, above_rst_s, below_trip_s, overcur_s;

  // Named views of the synchronised pins
  assign conn_a_n_s = sync2_q[PIN_CONN_A];
  assign conn_b_n_s = sync2_q[PIN_CONN_B];
  assign req_n_s = sync2_q[PIN_REQ_N];
  assign uvlo_ok_s = sync2_q[PIN_LO_UVLO] && sync2_q[PIN_HI_UVLO];
  assign above_rst_s = sync2_q[PIN_ABOVE_RST];
  assign below_trip_s = sync2_q[PIN_BELOW_TRIP];
  assign overcur_s = sync2_q[PIN_OVERCUR];

  // ==========================================================================
  // Qualification counters
  logic conn_done, req_done, oc_done, up_done, down_done;

  // Both connect senses low
  hip_qualify #(.COUNT(QUALIFY_COUNT)) u_conn_q (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .cond(!conn_a_n_s && !conn_b_n_s),
    .done_q(conn_done)
  );

  // Power-cycle request held low, short pulses dropped
  hip_qualify #(.COUNT(QUALIFY_COUNT)) u_req_q (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .cond(!req_n_s),
    .done_q(req_done)
  );

  // Overcurrent persistence
  hip_qualify #(.COUNT(BREAKER_CYC)) u_oc_q (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .cond(overcur_s),
    .done_q(oc_done)
  );

  // Output above reset threshold long enough
  hip_qualify #(.COUNT(SETTLE_COUNT)) u_up_q (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .cond(above_rst_s),
    .done_q(up_done)
  );

  // Output below reset threshold long enough
  hip_qualify #(.COUNT(RESET_DROP_CYC)) u_down_q (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .cond(!above_rst_s),
    .done_q(down_done)
  );

  // ==========================================================================
  // Power state machine
  hip_state_t state_q;
  hip_state_t state_d;
  logic ramp_d, pump_d, dis_d, neg_d, fault_n_d;
  logic clr_hold_q, clr_hold_d;

  // Next state and supply outputs
  always_comb begin
    state_d = state_q;
    fault_n_d = fault_n;
    clr_hold_d = clr_hold_q && req_done; // Clearing request still held
    unique case (state_q)
      ST_WAIT: begin
        if (conn_done && uvlo_ok_s) begin
          state_d = ST_ON;
        end
      end
      ST_ON: begin
        if (oc_done) begin
          state_d = ST_TRIPPED;
          fault_n_d = 1'b0;
        end else if ((req_done && !clr_hold_q) || conn_a_n_s || conn_b_n_s) begin
          state_d = ST_DISCHARGE;
        end
      end
      ST_DISCHARGE: begin
        // Hold while request low; leave only once outputs are down
        if (req_n_s && below_trip_s) begin
          state_d = ST_WAIT;
        end
      end
      ST_TRIPPED: begin
        if (req_done) begin
          state_d = ST_ON;
          fault_n_d = 1'b1;
          clr_hold_d = 1'b1;
        end else if (!uvlo_ok_s) begin
          state_d = ST_WAIT;
          fault_n_d = 1'b1;
        end
      end
    endcase
    // Supply drive decoded from the next state
    ramp_d = (state_d == ST_ON);
    pump_d = (state_d == ST_ON);
    neg_d = (state_d == ST_ON);
    dis_d = (state_d != ST_ON);
  end

  // State and supply registers
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      state_q <= ST_WAIT;
      ramp_current_en <= RST_LOW;
      low_rail_gate_drive <= RST_LOW;
      high_rail_gate_drive <= RST_LOW;
      gate_discharge <= RST_GATE_DISCHARGE;
      neg_supply_enable <= RST_LOW;
      fault_n <= RST_FAULT_N;
      clr_hold_q <= RST_LOW;
    end else begin
      state_q <= state_d;
      ramp_current_en <= ramp_d;
      low_rail_gate_drive <= pump_d;
      high_rail_gate_drive <= pump_d;
      gate_discharge <= dis_d;
      neg_supply_enable <= neg_d;
      fault_n <= fault_n_d;
      clr_hold_q <= clr_hold_d;
    end
  end

  // ==========================================================================
  // Supply-good, system reset and bus isolation
  logic pg_d, rst_n_d, iso_d;

  // Reset only moves on a fully qualified excursion
  always_comb begin
    pg_d = above_rst_s;
    rst_n_d = sys_reset_n;
    iso_d = bus_isolate;
    if (up_done) begin
      rst_n_d = 1'b1;
      iso_d = 1'b0;
    end else if (down_done) begin
      rst_n_d = 1'b0;
      iso_d = 1'b1;
    end
  end

  // Supervisor registers
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      supply_good_out <= RST_LOW;
      sys_reset_n <= RST_SYS_RESET_N;
      bus_isolate <= RST_BUS_ISOLATE;
    end else begin
      supply_good_out <= pg_d;
      sys_reset_n <= rst_n_d;
      bus_isolate <= iso_d;
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  chk_no_unqualified_up: assert property (
    (state_q == ST_WAIT && !conn_done) |=> state_q != ST_ON)
    else $error("power-up without qualified connection");
  chk_on_drive_set: assert property (
    state_q == ST_ON |-> (neg_supply_enable && ramp_current_en && low_rail_gate_drive
                          && high_rail_gate_drive && !gate_discharge))
    else $error("on state without full supply drive");
  chk_isolate_at_boot: assert property (
    $rose(resetn) |-> bus_isolate && !sys_reset_n)
    else $error("bus not isolated after power-up");
  chk_pgood_follows: assert property (
    ##1 supply_good_out == $past(above_rst_s))
    else $error("supply-good does not follow comparator");
  chk_reset_release: assert property (
    $rose(sys_reset_n) |-> $past(up_done) && !bus_isolate)
    else $error("reset released without settle delay");
  chk_cycle_start: assert property (
    (state_q == ST_ON && req_done && !clr_hold_q && !oc_done) |=> state_q == ST_DISCHARGE)
    else $error("qualified request did not start cycle");
  chk_short_ignored: assert property (
    (state_q == ST_ON && !req_done && !oc_done && !conn_a_n_s && !conn_b_n_s)
    |=> state_q == ST_ON)
    else $error("unqualified request changed state");
  chk_discharge_drive: assert property (
    state_q == ST_DISCHARGE |-> (!neg_supply_enable && gate_discharge
                                 && !low_rail_gate_drive))
    else $error("discharge state still driving supplies");
  chk_reset_drop: assert property (
    $fell(sys_reset_n) |-> $past(down_done) && bus_isolate)
    else $error("reset asserted without 32 us delay");
  chk_hold_while_low: assert property (
    (state_q == ST_DISCHARGE && !req_n_s) |=> state_q == ST_DISCHARGE)
    else $error("left discharge while request low");
  chk_trip_enter: assert property (
    (state_q == ST_ON && oc_done) |=> (state_q == ST_TRIPPED && !fault_n
                                       && !neg_supply_enable && gate_discharge))
    else $error("breaker trip not taken");
  chk_trip_clear: assert property (
    (state_q == ST_TRIPPED && req_done) |=> (state_q == ST_ON && fault_n && neg_supply_enable))
    else $error("qualified request did not clear breaker");
  chk_trip_hold: assert property (
    (state_q == ST_TRIPPED && !req_done && uvlo_ok_s) |=> state_q == ST_TRIPPED)
    else $error("tripped state left without clear");
  chk_removal: assert property (
    (state_q == ST_ON && !oc_done && (conn_a_n_s || conn_b_n_s))
    |=> state_q == ST_DISCHARGE)
    else $error("removal did not discharge");

  cov_power_up: cover property (state_q == ST_WAIT ##1 state_q == ST_ON);
  cov_cycle: cover property (state_q == ST_DISCHARGE ##1 state_q == ST_WAIT);
  cov_trip_clear: cover property (state_q == ST_TRIPPED ##1 state_q == ST_ON);
  cov_reset_release: cover property ($rose(sys_reset_n));

endmodule

// [rtl/hip_pkg.sv]
// Constants, timing and state type shared by the hot-insertion sequencer
package hip_pkg;

  // ==========================================================================
  // Clock rate
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;

  // ==========================================================================
  // Times as printed
  localparam int unsigned QUALIFY_MS = 20;   // Connect and power-cycle qualification
  localparam int unsigned SETTLE_MS = 200;   // Supply-good to reset release
  localparam int unsigned RESET_DROP_US = 32; // Supply-good loss to reset assert
  localparam int unsigned BREAKER_US = 20;   // Overcurrent persistence

  // ==========================================================================
  // Times as cycle counts
  localparam int unsigned QUALIFY_CYC = QUALIFY_MS * CYC_PER_MS;
  localparam int unsigned SETTLE_CYC = SETTLE_MS * CYC_PER_MS;
  localparam int unsigned RESET_DROP_CYC = RESET_DROP_US * CYC_PER_US;
  localparam int unsigned BREAKER_CYC = BREAKER_US * CYC_PER_US;

  // ==========================================================================
  // Positions of pin inputs in the synchroniser vector
  localparam int unsigned SYNC_W = 8;
  localparam int unsigned PIN_CONN_A = 0;
  localparam int unsigned PIN_CONN_B = 1;
  localparam int unsigned PIN_REQ_N = 2;
  localparam int unsigned PIN_LO_UVLO = 3;
  localparam int unsigned PIN_HI_UVLO = 4;
  localparam int unsigned PIN_ABOVE_RST = 5;
  localparam int unsigned PIN_BELOW_TRIP = 6;
  localparam int unsigned PIN_OVERCUR = 7;

  // ==========================================================================
  // Values after reset
  localparam logic [7:0] RST_SYNC = 8'h04;   // Request input idles high
  localparam logic RST_BUS_ISOLATE = 1'b1;   // Bus switch off on power
  localparam logic RST_SYS_RESET_N = 1'b0;
  localparam logic RST_FAULT_N = 1'b1;
  localparam logic RST_GATE_DISCHARGE = 1'b1; // Gates held low at power
  localparam logic RST_LOW = 1'b0;

  // ==========================================================================
  // Sequencer states
  typedef enum logic [1:0] {
    ST_WAIT,
    ST_ON,
    ST_DISCHARGE,
    ST_TRIPPED
  } hip_state_t;

endpackage

// [rtl/hip_qualify.sv]
// Qualification counter: a condition must hold for a full count
`timescale 1ns/1ps
module hip_qualify
  import hip_pkg::*;
#(
  parameter int unsigned COUNT = 4
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Condition and result
  input wire logic cond,
  output logic done_q
);

  localparam int unsigned CW = $clog2(COUNT + 1);

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic done_d;

  // ==========================================================================
  // Count while held, restart on loss
  always_comb begin
    cnt_d = cnt_q;
    done_d = done_q;
    if (!cond) begin
      cnt_d = '0;
      done_d = 1'b0;
    end else if (cnt_q == CW'(COUNT)) begin
      done_d = 1'b1;
    end else begin
      cnt_d = cnt_q + 1'b1;
    end
  end

  // Registers
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      cnt_q <= '0;
      done_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      done_q <= done_d;
    end
  end

  // ==========================================================================
  // Checks
  chk_loss_restart: assert property (@(posedge ref_clk) disable iff (!resetn)
    !cond |=> (!done_q && cnt_q == '0))
    else $error("qualifier did not restart on loss");

  chk_no_early_done: assert property (@(posedge ref_clk) disable iff (!resetn)
    $rose(done_q) |-> $past(cond) && $past(cnt_q) == CW'(COUNT))
    else $error("qualifier finished before full count");

endmodule

// [verif/hip_board_model.sv]
// Board-side model: output rails, discharge level and overcurrent sense
`timescale 1ns/1ps
module hip_board_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Drives from the sequencer
  input wire logic high_rail_gate_drive,
  input wire logic gate_discharge,
  // Scenario commands
  input wire logic short_cmd,
  input wire logic dip_cmd,
  // Analog status back to the sequencer
  output logic low_rail_output_ok,
  output logic outputs_below_trip,
  output logic overcurrent_sense
);
  logic [5:0] lvl_q;

  // ==========================================================================
  // Output level: ramps up with the pumps, falls with the pulldown
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      lvl_q <= 6'h00;
    end else if (gate_discharge && lvl_q != 6'h00) begin
      lvl_q <= lvl_q - 6'h01;
    end else if (high_rail_gate_drive && !gate_discharge && lvl_q != 6'h3f) begin
      lvl_q <= lvl_q + 6'h01;
    end
  end

  // Comparators; a dip forces the reset comparator low for a while
  assign low_rail_output_ok = (lvl_q > 6'h28) && !dip_cmd;
  assign outputs_below_trip = (lvl_q < 6'h04);
  // Current flows into the short only while the pass device is on
  assign overcurrent_sense = short_cmd && high_rail_gate_drive;
endmodule

// [verif/test_hot_insert_power_sequencer.sv]
// Self-checking bench for the hot-insertion power sequencer
`timescale 1ns/1ps
module test_hot_insert_power_sequencer;
  import hip_pkg::*;
  localparam int QC = 20;
  localparam int SC = 50;
  logic ref_clk, resetn, conn_a_n, conn_b_n, req_n, lo_ok, hi_ok, short_cmd, dip_cmd;
  logic out_ok, below_trip, overcur, ramp_en, lo_gate, hi_gate, gate_dis, neg_en;
  logic supply_good, sys_reset_n, bus_isolate, fault_n;
  int err_count;
  int check_count;
  int n;

  // ==========================================================================
  // Clock, design and board model
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  hip_sequencer #(.QUALIFY_COUNT(QC), .SETTLE_COUNT(SC)) u_hip_sequencer (
    .ref_clk(ref_clk), .resetn(resetn), .connect_sense_a_n(conn_a_n),
    .connect_sense_b_n(conn_b_n), .pwr_cycle_req_n(req_n), .low_rail_input_ok(lo_ok),
    .high_rail_input_ok(hi_ok), .low_rail_output_ok(out_ok),
    .outputs_below_trip(below_trip), .overcurrent_sense(overcur),
    .ramp_current_en(ramp_en), .low_rail_gate_drive(lo_gate),
    .high_rail_gate_drive(hi_gate), .gate_discharge(gate_dis),
    .neg_supply_enable(neg_en), .supply_good_out(supply_good),
    .sys_reset_n(sys_reset_n), .bus_isolate(bus_isolate), .fault_n(fault_n));

  hip_board_model u_hip_board_model (
    .ref_clk(ref_clk), .resetn(resetn), .high_rail_gate_drive(hi_gate),
    .gate_discharge(gate_dis), .short_cmd(short_cmd), .dip_cmd(dip_cmd),
    .low_rail_output_ok(out_ok), .outputs_below_trip(below_trip),
    .overcurrent_sense(overcur));

  // ==========================================================================
  // Shared helpers
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input logic seen, input logic exp, input string msg);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: %s seen %b expected %b", $time, msg, seen, exp);
    end
  endtask

  task automatic tick(input int cnt);
    repeat (cnt) @(posedge ref_clk);
    #1;
  endtask

  function automatic logic sel(input int w);
    case (w)
      0: sel = ramp_en;
      1: sel = neg_en;
      2: sel = supply_good;
      3: sel = sys_reset_n;
      4: sel = fault_n;
      5: sel = below_trip;
      default: sel = out_ok;
    endcase
  endfunction

  // Bounded wait for one watched signal, then judge it
  task automatic wait_for(input int w, input logic v, input int lim, output int cnt);
    cnt = 0;
    while (sel(w) !== v && cnt < lim) begin
      tick(1);
      cnt++;
    end
    check(sel(w), v, "bounded wait");
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_power_up();
    conn_a_n = 1'b0;
    tick(QC + 10);
    check(ramp_en, 1'b0, "one sense only");
    conn_b_n = 1'b0;
    tick(QC - 5);
    conn_b_n = 1'b1;
    tick(2);
    conn_b_n = 1'b0;
    tick(QC - 5);
    check(ramp_en, 1'b0, "bounce restarts count");
    hi_ok = 1'b0;
    tick(QC);
    check(ramp_en, 1'b0, "high lockout holds off");
    hi_ok = 1'b1;
    lo_ok = 1'b0;
    tick(QC);
    check(ramp_en, 1'b0, "low lockout holds off");
    lo_ok = 1'b1;
    wait_for(0, 1'b1, 10, n);
    check(lo_gate & hi_gate & neg_en, 1'b1, "pumps and neg on");
    check(gate_dis, 1'b0, "pulldown off");
    check(bus_isolate, 1'b1, "bus off while ramping");
    wait_for(6, 1'b1, 100, n);
    tick(3);
    check(supply_good, 1'b1, "supply good follows");
    wait_for(3, 1'b1, SC + 10, n);
    check(logic'(n >= SC - 3 && n <= SC + 2), 1'b1, "settle delay");
    check(bus_isolate, 1'b0, "bus enabled");
  endtask

  task automatic t_short_req();
    req_n = 1'b0;
    tick(QC - 5);
    req_n = 1'b1;
    tick(10);
    check(neg_en & sys_reset_n, 1'b1, "short pulse ignored");
  endtask

  task automatic t_dip();
    dip_cmd = 1'b1;
    tick(100);
    check(supply_good, 1'b0, "supply good drops on dip");
    check(sys_reset_n, 1'b1, "reset kept on short dip");
    dip_cmd = 1'b0;
    tick(10);
    check(supply_good, 1'b1, "supply good back");
  endtask

  task automatic t_cycle(input logic early);
    req_n = 1'b0;
    wait_for(1, 1'b0, QC + 10, n);
    check(gate_dis, 1'b1, "gates pulled down");
    check(lo_gate | hi_gate | ramp_en, 1'b0, "pumps off");
    if (early) begin
      req_n = 1'b1;
      wait_for(5, 1'b1, 100, n);
      check(ramp_en, 1'b0, "discharge continues");
    end else begin
      wait_for(2, 1'b0, 100, n);
      wait_for(3, 1'b0, 3300, n);
      check(logic'(n >= 3195 && n <= 3205), 1'b1, "reset drop delay");
      check(bus_isolate, 1'b1, "bus isolated");
      check(below_trip & gate_dis & ~ramp_en, 1'b1, "held while request low");
      req_n = 1'b1;
    end
    wait_for(0, 1'b1, 20, n);
    wait_for(3, 1'b1, SC + 200, n);
  endtask

  task automatic t_remove();
    conn_a_n = 1'b1;
    wait_for(1, 1'b0, 10, n);
    check(gate_dis, 1'b1, "removal pulls down");
    conn_a_n = 1'b0;
    wait_for(5, 1'b1, 100, n);
    wait_for(0, 1'b1, QC + 20, n);
    wait_for(3, 1'b1, SC + 200, n);
  endtask

  task automatic t_trip();
    short_cmd = 1'b1;
    tick(1000);
    short_cmd = 1'b0;
    tick(10);
    check(fault_n, 1'b1, "brief overcurrent ignored");
    short_cmd = 1'b1;
    wait_for(4, 1'b0, 2100, n);
    check(logic'(n >= 1990), 1'b1, "breaker persistence");
    check(neg_en | ramp_en | lo_gate | hi_gate, 1'b0, "drives off on trip");
    check(gate_dis, 1'b1, "outputs grounded");
    short_cmd = 1'b0;
    tick(200);
    check(fault_n, 1'b0, "trip latched");
    req_n = 1'b0;
    wait_for(4, 1'b1, QC + 10, n);
    tick(5);
    check(neg_en & ramp_en & lo_gate & hi_gate, 1'b1, "breaker cleared");
    req_n = 1'b1;
    wait_for(3, 1'b1, SC + 200, n);
  endtask

  task automatic t_trip_supply();
    short_cmd = 1'b1;
    wait_for(4, 1'b0, 2100, n);
    short_cmd = 1'b0;
    hi_ok = 1'b0;
    wait_for(4, 1'b1, 10, n);
    check(ramp_en | neg_en, 1'b0, "supply loss leaves trip idle");
    hi_ok = 1'b1;
    wait_for(0, 1'b1, 10, n);
    check(fault_n, 1'b1, "fault cleared by supply cycle");
  endtask

  // ==========================================================================
  // Watchdog and main sequence
  initial begin
    repeat (60000) @(posedge ref_clk);
    err_count++;
    end_sim();
  end

  initial begin
    err_count = 0;
    check_count = 0;
    resetn = 1'b0;
    conn_a_n = 1'b1;
    conn_b_n = 1'b1;
    req_n = 1'b1;
    lo_ok = 1'b1;
    hi_ok = 1'b1;
    short_cmd = 1'b0;
    dip_cmd = 1'b0;
    tick(5);
    check(sys_reset_n | supply_good | ramp_en, 1'b0, "reset drives low");
    check(bus_isolate & gate_dis & fault_n, 1'b1, "reset isolates bus");
    resetn = 1'b1;
    t_power_up();
    t_short_req();
    t_dip();
    t_cycle(1'b0);
    t_cycle(1'b1);
    t_remove();
    t_trip();
    t_trip_supply();
    end_sim();
  end
endmodule
